// File: bwd_regs.svh
// constants of the board watchdog: port offsets, config registers, fields, timing
// assumes inclusion by bare name from the watchdog design files
`ifndef BWD_REGS_SVH
`define BWD_REGS_SVH
// host-visible port offsets on the plain register port
`define BWD_ADDR_INDEX 8'h2e
`define BWD_ADDR_DATA 8'h2f
`define BWD_ADDR_IRQ_STAT 8'h30
`define BWD_ADDR_IRQ_MASK 8'h31
// index port codes
`define BWD_UNLOCK_CODE 8'h87
`define BWD_LOCK_CODE 8'haa
// configuration register numbers
`define BWD_REG_LDN 8'h07
`define BWD_REG_ACT 8'h30
`define BWD_REG_UNIT 8'hf5
`define BWD_REG_COUNT 8'hf6
`define BWD_REG_CTRL 8'hf7
`define BWD_LDN_WDT 8'h08
// field positions
`define BWD_ACT_EN_BIT 0
`define BWD_UNIT_MIN_BIT 3
`define BWD_CTRL_STAT_BIT 4
`define BWD_CTRL_FORCE_BIT 5
`define BWD_CTRL_KBD_BIT 6
`define BWD_IRQ_TIMEOUT_BIT 0
`define BWD_IRQ_KBD_BIT 1
// reset values
`define BWD_RST_BYTE 8'h00
`define BWD_RST_IRQ 2'h0
// timing
`define BWD_CLK_PERIOD_NS 5
`define BWD_SEC_NS 1000000000
`define BWD_SEC_CYCLES (`BWD_SEC_NS / `BWD_CLK_PERIOD_NS)
`define BWD_SEC_PER_MIN 60
`endif

// File: bwd_pkg.sv
// types shared by the board watchdog design files
// assumes nothing beyond a SystemVerilog compiler
package bwd_pkg;
	typedef logic [7:0] bwd_byte_t;
	typedef logic [1:0] bwd_irq_t;
	typedef enum logic [1:0] {CFG_LOCKED, CFG_HALF, CFG_OPEN} bwd_cfg_state_t;
endpackage

// File: bwd_sync.sv
// two-flop synchroniser for board-level pins
// assumes inputs arrive asynchronously to i_mclk
`timescale 1ns/100ps
module bwd_sync #(
	parameter int W = 2
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;

	// first stage feeds only the second stage
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			meta_reg <= '0;
			o_sync <= '0;
		end else begin
			meta_reg <= i_async;
			o_sync <= meta_reg;
		end
	end
endmodule // bwd_sync

// File: bwd_tick_gen.sv
// unit tick generator: one pulse per second or per minute while running
// assumes i_restart realigns the prescaler to a full unit
`timescale 1ns/100ps
`include "bwd_regs.svh"
module bwd_tick_gen #(
	parameter int SEC_CYCLES = `BWD_SEC_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_run,
	input wire logic i_restart,
	input wire logic i_unit_min,
	output logic o_tick
);
	localparam int CW = (SEC_CYCLES > 2) ? $clog2(SEC_CYCLES) : 1;
	logic [CW-1:0] cyc_reg;
	logic [5:0] sec_reg;
	wire sec_end = (cyc_reg == CW'(SEC_CYCLES - 1));
	wire min_end = (sec_reg == 6'(`BWD_SEC_PER_MIN - 1));
	wire unit_end = sec_end && (!i_unit_min || min_end);

	// prescaler counts clock cycles into seconds and seconds into minutes
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cyc_reg <= '0;
			sec_reg <= 6'h00;
			o_tick <= 1'b0;
		end else if (!i_run || i_restart) begin
			cyc_reg <= '0;
			sec_reg <= 6'h00;
			o_tick <= 1'b0;
		end else begin
			cyc_reg <= sec_end ? '0 : cyc_reg + 1'b1;
			if (sec_end) begin
				sec_reg <= (min_end || !i_unit_min) ? 6'h00 : sec_reg + 6'h01;
			end
			o_tick <= unit_end;
		end
	end
endmodule // bwd_tick_gen

// File: bwd_watchdog.sv
// board watchdog timer behind an index/data port pair with unlock sequence
// assumes a same-clock register master; jumper and keyboard pins are asynchronous
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/100ps
`include "bwd_regs.svh"
module bwd_watchdog #(
	parameter int SEC_CYCLES = `BWD_SEC_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire bwd_pkg::bwd_byte_t i_addr,
	input wire bwd_pkg::bwd_byte_t i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output bwd_pkg::bwd_byte_t o_rdata,
	input wire logic i_timeout_action_select_jumper,
	input wire logic i_kbd_activity,
	output logic o_irq11_n,
	output logic o_cpu_reset,
	output logic o_irq
);
	import bwd_pkg::*;

	// true for registers that belong to the watchdog logical device
	function automatic logic is_wdt_reg(input bwd_byte_t idx);
		return idx == `BWD_REG_ACT || idx == `BWD_REG_UNIT ||
			idx == `BWD_REG_COUNT || idx == `BWD_REG_CTRL;
	endfunction

	bwd_cfg_state_t cfg_reg, cfg_next;
	bwd_byte_t index_reg;
	bwd_byte_t ldn_reg;
	logic act_en_reg;
	logic unit_min_reg;
	bwd_byte_t count_reg;
	bwd_byte_t cur_reg, cur_next;
	logic kbd_en_reg;
	logic fired_reg, fired_next;
	logic kbd_prev_reg;
	bwd_irq_t irq_stat_reg, irq_mask_reg, irq_stat_next;
	logic [1:0] pins_s;
	logic tick;

	// pin synchronisers: bit 1 jumper, bit 0 keyboard
	bwd_sync #(.W(2)) u_sync (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_async({i_timeout_action_select_jumper, i_kbd_activity}),
		.o_sync(pins_s)
	);
	wire jumper_irq = pins_s[1]; // high routes timeout to the interrupt line
	wire kbd_s = pins_s[0];

	// port decode
	wire idx_wr = i_wr && i_addr == `BWD_ADDR_INDEX;
	wire cfg_open = cfg_reg == CFG_OPEN;
	wire wdt_sel = ldn_reg == `BWD_LDN_WDT;
	wire data_wr = i_wr && i_addr == `BWD_ADDR_DATA && cfg_open;
	wire reg_wr = data_wr && (index_reg == `BWD_REG_LDN || (wdt_sel && is_wdt_reg(index_reg)));
	wire act_wr = reg_wr && index_reg == `BWD_REG_ACT;
	wire unit_wr = reg_wr && index_reg == `BWD_REG_UNIT;
	wire count_wr = reg_wr && index_reg == `BWD_REG_COUNT;
	wire ctrl_wr = reg_wr && index_reg == `BWD_REG_CTRL;
	wire force_wr = ctrl_wr && i_wdata[`BWD_CTRL_FORCE_BIT];
	wire stat_wr = i_wr && i_addr == `BWD_ADDR_IRQ_STAT;
	wire mask_wr = i_wr && i_addr == `BWD_ADDR_IRQ_MASK;

	// restart sources and expiry
	wire kbd_rise = kbd_s && !kbd_prev_reg;
	wire kbd_restart = kbd_rise && kbd_en_reg && act_en_reg;
	wire restart = count_wr || kbd_restart;
	wire running = act_en_reg && cur_reg != 8'h00 && !fired_reg;
	wire expire = tick && cur_reg == 8'h01;
	wire fire = act_en_reg && (expire || force_wr);

	// unit tick source
	bwd_tick_gen #(.SEC_CYCLES(SEC_CYCLES)) u_tick (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_run(running),
		.i_restart(restart),
		.i_unit_min(unit_min_reg),
		.o_tick(tick)
	);

	// unlock sequence: two unlock codes open, lock code closes
	always_comb begin
		cfg_next = cfg_reg;
		if (idx_wr) begin
			case (cfg_reg)
				CFG_LOCKED: cfg_next = (i_wdata == `BWD_UNLOCK_CODE) ? CFG_HALF : CFG_LOCKED;
				CFG_HALF: cfg_next = (i_wdata == `BWD_UNLOCK_CODE) ? CFG_OPEN : CFG_LOCKED;
				CFG_OPEN: cfg_next = (i_wdata == `BWD_LOCK_CODE) ? CFG_LOCKED : CFG_OPEN;
				default: cfg_next = CFG_LOCKED;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cfg_reg <= CFG_LOCKED;
			index_reg <= `BWD_RST_BYTE;
		end else begin
			cfg_reg <= cfg_next;
			if (idx_wr && cfg_open && i_wdata != `BWD_LOCK_CODE) begin
				index_reg <= i_wdata;
			end
		end
	end

	// configuration registers
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ldn_reg <= `BWD_RST_BYTE;
			act_en_reg <= 1'b0;
			unit_min_reg <= 1'b0;
			count_reg <= `BWD_RST_BYTE;
			kbd_en_reg <= 1'b0;
		end else begin
			if (reg_wr && index_reg == `BWD_REG_LDN) begin
				ldn_reg <= i_wdata;
			end
			if (act_wr) begin
				act_en_reg <= i_wdata[`BWD_ACT_EN_BIT];
			end
			if (unit_wr) begin
				unit_min_reg <= i_wdata[`BWD_UNIT_MIN_BIT];
			end
			if (count_wr) begin
				count_reg <= i_wdata;
			end
			if (ctrl_wr) begin
				kbd_en_reg <= i_wdata[`BWD_CTRL_KBD_BIT];
			end
		end
	end

	// countdown and timeout state
	always_comb begin
		cur_next = cur_reg;
		if (count_wr) begin
			cur_next = i_wdata;
		end else if (kbd_restart) begin
			cur_next = count_reg;
		end else if (tick && cur_reg != 8'h00) begin
			cur_next = cur_reg - 8'h01;
		end
		fired_next = fired_reg;
		if (!act_en_reg) begin
			fired_next = 1'b0;
		end else if (fire) begin
			fired_next = 1'b1;
		end else if (restart) begin
			fired_next = 1'b0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cur_reg <= `BWD_RST_BYTE;
			fired_reg <= 1'b0;
			kbd_prev_reg <= 1'b0;
		end else begin
			cur_reg <= cur_next;
			fired_reg <= fired_next;
			kbd_prev_reg <= kbd_s;
		end
	end

	// timeout action routed by the jumper
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq11_n <= 1'b1;
			o_cpu_reset <= 1'b0;
		end else begin
			o_irq11_n <= !(fired_reg && jumper_irq);
			o_cpu_reset <= fired_reg && !jumper_irq;
		end
	end

	// sticky event bits, set wins over write-one-to-clear
	always_comb begin
		irq_stat_next = irq_stat_reg & ~(stat_wr ? i_wdata[1:0] : 2'h0);
		irq_stat_next[`BWD_IRQ_TIMEOUT_BIT] = irq_stat_next[`BWD_IRQ_TIMEOUT_BIT] | fire;
		irq_stat_next[`BWD_IRQ_KBD_BIT] = irq_stat_next[`BWD_IRQ_KBD_BIT] | kbd_restart;
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			irq_stat_reg <= `BWD_RST_IRQ;
			irq_mask_reg <= `BWD_RST_IRQ;
		end else begin
			irq_stat_reg <= irq_stat_next;
			if (mask_wr) begin
				irq_mask_reg <= i_wdata[1:0];
			end
		end
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	// read selection; force bit always reads back zero
	wire [7:0] ctrl_val = {1'b0, kbd_en_reg, 1'b0, fired_reg, 4'h0};
	wire [7:0] cfg_val =
		(index_reg == `BWD_REG_LDN) ? ldn_reg :
		!wdt_sel ? 8'h00 :
		(index_reg == `BWD_REG_ACT) ? {7'h00, act_en_reg} :
		(index_reg == `BWD_REG_UNIT) ? {4'h0, unit_min_reg, 3'h0} :
		(index_reg == `BWD_REG_COUNT) ? cur_reg :
		(index_reg == `BWD_REG_CTRL) ? ctrl_val : 8'h00;
	wire [7:0] rd_val =
		(i_addr == `BWD_ADDR_INDEX) ? index_reg :
		(i_addr == `BWD_ADDR_DATA && cfg_open) ? cfg_val :
		(i_addr == `BWD_ADDR_IRQ_STAT) ? {6'h00, irq_stat_reg} :
		(i_addr == `BWD_ADDR_IRQ_MASK) ? {6'h00, irq_mask_reg} : 8'h00;

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= `BWD_RST_BYTE;
		end else if (i_rd) begin
			o_rdata <= rd_val;
		end
	end

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);

	off_no_action_a: assert property (
		!act_en_reg |-> ##2 (o_irq11_n && !o_cpu_reset))
		else $error("timeout action while watchdog disabled");
	count_load_a: assert property (
		count_wr |=> cur_reg == $past(i_wdata) && !fired_reg)
		else $error("count write did not reload timer");
	zero_stops_a: assert property (
		cur_reg == 8'h00 && !restart |=> cur_reg == 8'h00 && !tick)
		else $error("timer moved with zero count");
	expiry_fires_a: assert property (
		act_en_reg && expire |=> fired_reg ##1 (!o_irq11_n || o_cpu_reset))
		else $error("expiry without timeout action");
	tick_decrement_a: assert property (
		tick && !restart && cur_reg != 8'h00 |=> cur_reg == $past(cur_reg) - 8'h01)
		else $error("tick did not decrement count");
	jumper_route_a: assert property (
		fired_reg |=> (o_irq11_n != $past(jumper_irq)) && (o_cpu_reset == !$past(jumper_irq)))
		else $error("timeout routed to wrong output");
	irq_level_hold_a: assert property (
		!o_irq11_n && fired_reg && !restart && act_en_reg && jumper_irq |=> ##1 !o_irq11_n)
		else $error("interrupt released without restart");
	irq_low_level_a: assert property (
		!o_irq11_n |-> $past(fired_reg))
		else $error("interrupt low without timeout");
	unlock_order_a: assert property (
		idx_wr && cfg_reg == CFG_LOCKED |=> cfg_reg != CFG_OPEN)
		else $error("opened without double unlock");
	unit_select_a: assert property (
		unit_wr |=> unit_min_reg == $past(i_wdata[`BWD_UNIT_MIN_BIT]))
		else $error("unit bit not taken");
	force_fire_a: assert property (
		force_wr && act_en_reg |=> fired_reg && irq_stat_reg[`BWD_IRQ_TIMEOUT_BIT])
		else $error("forced timeout missing");

	expire_c: cover property (act_en_reg && expire ##[1:4] !o_irq11_n);
	reset_route_c: cover property (o_cpu_reset);
	kbd_restart_c: cover property (fired_reg && kbd_restart);
	unlock_c: cover property (cfg_reg == CFG_HALF ##1 cfg_reg == CFG_OPEN);
endmodule // bwd_watchdog

// File: bwd_board_model.sv
// board side of the watchdog: latches reset and interrupt requests
// assumes the watchdog outputs are levels in the i_mclk domain
`timescale 1ns/100ps
module bwd_board_model (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_irq11_n,
	input wire logic i_cpu_reset,
	output logic o_irq_seen,
	output logic o_reset_seen
);
	// level capture, as a controller on a low level line would see it
	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_irq_seen <= 1'b0;
			o_reset_seen <= 1'b0;
		end else begin
			o_irq_seen <= o_irq_seen | ~i_irq11_n;
			o_reset_seen <= o_reset_seen | i_cpu_reset;
		end
	end
endmodule // bwd_board_model

// File: bwd_watchdog_bench.sv
// directed tests of the board watchdog through its register port
// assumes bwd_pkg, bwd_regs.svh and the design files compile first
`timescale 1ns/100ps
`include "bwd_regs.svh"
module bwd_watchdog_bench;
	import bwd_pkg::*;
	localparam int SC = 4;
	logic i_mclk = 1'b0;
	logic i_reset_n = 1'b0;
	bwd_byte_t i_addr = 8'h00;
	bwd_byte_t i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_jmp = 1'b1;
	logic i_kbd = 1'b0;
	bwd_byte_t o_rdata;
	logic o_irq11_n;
	logic o_cpu_reset;
	logic o_irq;
	logic o_irq_seen;
	logic o_reset_seen;
	int n_errors = 0;
	int cmp_count = 0;
	bwd_byte_t rv;
	// 200 MHz clock
	initial begin
		forever #2.5 i_mclk = ~i_mclk;
	end
	// a short second keeps timeouts within a few cycles
	bwd_watchdog #(.SEC_CYCLES(SC)) u_bwd_watchdog (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_timeout_action_select_jumper(i_jmp), .i_kbd_activity(i_kbd),
		.o_irq11_n(o_irq11_n), .o_cpu_reset(o_cpu_reset), .o_irq(o_irq));
	bwd_board_model u_bwd_board_model (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
		.i_irq11_n(o_irq11_n), .i_cpu_reset(o_cpu_reset),
		.o_irq_seen(o_irq_seen), .o_reset_seen(o_reset_seen));
	// verdict and end of run
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input bwd_byte_t seen, input bwd_byte_t exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// pin word: irq11_n, cpu_reset, irq
	task automatic pins(input bwd_byte_t exp);
		chk("pins", {5'h00, o_irq11_n, o_cpu_reset, o_irq}, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask
	task automatic wr(input bwd_byte_t a, input bwd_byte_t d);
		@(posedge i_mclk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_mclk);
		i_wr <= 1'b0;
	endtask
	// read data stand from the cycle after the strobe until the next read
	task automatic rd(input bwd_byte_t a, output bwd_byte_t d);
		@(posedge i_mclk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_mclk);
		i_rd <= 1'b0;
		#1;
		d = o_rdata;
	endtask
	task automatic set(input bwd_byte_t r, input bwd_byte_t v);
		wr(`BWD_ADDR_INDEX, r);
		wr(`BWD_ADDR_DATA, v);
	endtask
	task automatic get(input bwd_byte_t r, output bwd_byte_t d);
		wr(`BWD_ADDR_INDEX, r);
		rd(`BWD_ADDR_DATA, d);
	endtask
	// bounded wait for the interrupt line to go low
	task automatic wait_fire(input int n);
		int k;
		k = 0;
		while (o_irq11_n !== 1'b0 && k < n) begin
			cyc(1);
			k++;
		end
		if (o_irq11_n !== 1'b0) begin
			n_errors++;
			$display("unexpected fire wait expected low seen high");
			end_sim();
		end
	endtask
	initial begin
		#(100000 * 5);
		n_errors++;
		$display("unexpected run length expected end seen hang");
		end_sim();
	end
	initial begin
		repeat (10) @(posedge i_mclk);
		i_reset_n <= 1'b1;
		cyc(1);
		pins(8'h04);
		rd(`BWD_ADDR_DATA, rv);
		chk("locked data", rv, 8'h00);
		wr(`BWD_ADDR_INDEX, `BWD_UNLOCK_CODE);
		wr(`BWD_ADDR_INDEX, `BWD_UNLOCK_CODE);
		set(`BWD_REG_LDN, `BWD_LDN_WDT);
		set(`BWD_REG_ACT, 8'h01);
		wr(`BWD_ADDR_IRQ_MASK, 8'h01);
		get(`BWD_REG_UNIT, rv);
		chk("unit reset", rv, 8'h00);
		get(`BWD_REG_COUNT, rv);
		chk("count reset", rv, 8'h00);
		rd(8'h55, rv);
		chk("unmapped", rv, 8'h00);
		$display("test reset done");
		// three seconds run out, jumper on interrupt
		set(`BWD_REG_COUNT, 8'h03);
		cyc(3 * SC);
		pins(8'h04);
		cyc(4);
		pins(8'h01);
		chk("board irq", {7'h00, o_irq_seen}, 8'h01);
		cyc(40);
		pins(8'h01);
		get(`BWD_REG_CTRL, rv);
		chk("ctrl fired", rv, 8'h10);
		get(`BWD_REG_COUNT, rv);
		chk("count end", rv, 8'h00);
		set(`BWD_REG_COUNT, 8'hff);
		cyc(2);
		chk("irq line", {7'h00, o_irq11_n}, 8'h01);
		wr(`BWD_ADDR_IRQ_STAT, 8'h01);
		cyc(1);
		pins(8'h04);
		$display("test interrupt done");
		// forced timeout, jumper on cpu reset
		i_jmp <= 1'b0;
		set(`BWD_REG_COUNT, 8'h00);
		set(`BWD_REG_CTRL, 8'h20);
		cyc(2);
		pins(8'h07);
		chk("board reset", {7'h00, o_reset_seen}, 8'h01);
		get(`BWD_REG_CTRL, rv);
		chk("force clear", rv, 8'h10);
		set(`BWD_REG_COUNT, 8'h00);
		cyc(2);
		wr(`BWD_ADDR_IRQ_STAT, 8'h01);
		cyc(1);
		pins(8'h04);
		$display("test reset action done");
		// one minute
		i_jmp <= 1'b1;
		set(`BWD_REG_UNIT, 8'h08);
		set(`BWD_REG_COUNT, 8'h01);
		cyc(59 * SC);
		pins(8'h04);
		wait_fire(300);
		cyc(1);
		pins(8'h01);
		set(`BWD_REG_UNIT, 8'h00);
		set(`BWD_REG_COUNT, 8'h00);
		wr(`BWD_ADDR_IRQ_STAT, 8'h01);
		cyc(40);
		pins(8'h04);
		$display("test minutes done");
		// disabled: no action even when forced
		set(`BWD_REG_ACT, 8'h00);
		set(`BWD_REG_COUNT, 8'hff);
		get(`BWD_REG_COUNT, rv);
		chk("count max", rv, 8'hff);
		set(`BWD_REG_CTRL, 8'h20);
		cyc(20);
		pins(8'h04);
		$display("test disable done");
		// keyboard activity keeps restarting a two second count
		set(`BWD_REG_ACT, 8'h01);
		set(`BWD_REG_CTRL, 8'h40);
		wr(`BWD_ADDR_IRQ_STAT, 8'h03);
		set(`BWD_REG_COUNT, 8'h02);
		repeat (8) begin
			i_kbd <= 1'b1;
			cyc(2);
			i_kbd <= 1'b0;
			cyc(2);
		end
		pins(8'h04);
		rd(`BWD_ADDR_IRQ_STAT, rv);
		chk("kbd status", rv, 8'h02);
		wait_fire(30);
		wr(`BWD_ADDR_INDEX, `BWD_LOCK_CODE);
		rd(`BWD_ADDR_DATA, rv);
		chk("relocked", rv, 8'h00);
		pins(8'h01);
		$display("test keyboard done");
		end_sim();
	end
endmodule // bwd_watchdog_bench
